/* core/fie_en_field.sv */
// Module: one two-bit write-to-change interrupt enable field
`timescale 1ns/1ns
module fie_en_field
    import fie_pkg::*;
#(
    parameter logic RESET_ON = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Write
    input wire logic wr_i,
    input wire logic [1:0] code_i,
    // State
    output logic on_o,
    output logic [1:0] rd_code_o
);
    typedef struct packed {
        logic on;
    } fie_field_s;

    fie_field_s st_reg;
    fie_field_s st_next;

    always_comb begin
        st_next = st_reg;
        // Codes 0h and 2h leave the enable as it is
        if (wr_i && code_i == FIE_CODE_OFF) begin
            st_next.on = 1'b0;
        end else if (wr_i && code_i == FIE_CODE_ON) begin
            st_next.on = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '{on: RESET_ON};
        end else begin
            st_reg <= st_next;
        end
    end

    assign on_o = st_reg.on;
    assign rd_code_o = st_reg.on ? FIE_READ_ON : FIE_READ_OFF;

    AST_NOP_KEEPS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_i && !code_i[0] |=> $stable(on_o))
        else $error("enable changed on a no-op code");
    AST_CODE_ACTS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_i && code_i[0] |=> on_o == $past(code_i[1]))
        else $error("enable code not applied");
endmodule

/* core/fie_pkg.sv */
// Package: register map, field layout, reset values and carrier types of the fault interrupt-enable block
package fie_pkg;
    // ==========================================
    // Register offsets (byte addresses on the plain port)
    localparam logic [7:0] FIE_OFF_DETECT_CFG = 8'h06;
    localparam logic [7:0] FIE_OFF_SUPPLY_EN = 8'h08;
    localparam logic [7:0] FIE_OFF_BOOST_EN = 8'h0A;
    localparam logic [7:0] FIE_OFF_FAULT_STAT = 8'h10;
    localparam logic [7:0] FIE_OFF_FAULT_MASK = 8'h12;
    localparam logic [7:0] FIE_OFF_STAT_CLEAR = 8'h14;

    // ==========================================
    // Reset values
    localparam logic [15:0] FIE_RST_DETECT_CFG = 16'h0100;
    localparam logic [15:0] FIE_RST_SUPPLY_EN = 16'h2AAA;
    localparam logic [15:0] FIE_RST_BOOST_EN = 16'hA028;
    localparam logic [15:0] FIE_RST_MASK = 16'hFFFF;

    // ==========================================
    // Field layout
    localparam int FIE_GND_DET_BIT = 8;
    localparam int FIE_STRINGS = 6;
    localparam logic [15:0] FIE_DETECT_CFG_MASK = 16'h013F;
    localparam int FIE_SUPPLY_FIELDS = 7;
    localparam int FIE_BOOST_FIELDS = 7;
    localparam int FIE_BOOST_FIRST = 1;
    localparam int FIE_SOURCES = 14;

    // Two-bit enable field codes
    localparam logic [1:0] FIE_CODE_OFF = 2'h1;
    localparam logic [1:0] FIE_CODE_ON = 2'h3;
    localparam logic [1:0] FIE_READ_OFF = 2'h0;
    localparam logic [1:0] FIE_READ_ON = 2'h2;

    // ==========================================
    // Carrier types
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } fie_bus_s;

    typedef struct packed {
        logic ground_short_detect_on;
        logic [5:0] internal_short_off;
    } fie_detect_s;
endpackage

/* core/fie_sticky.sv */
// Module: one sticky fault flag with paired status-and-clear write
`timescale 1ns/1ns
module fie_sticky (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Event and clear
    input wire logic event_i,
    input wire logic clear_i,
    // Flag
    output logic flag_o
);
    typedef struct packed {
        logic flag;
    } fie_flag_s;

    fie_flag_s st_reg;
    fie_flag_s st_next;

    always_comb begin
        st_next = st_reg;
        // Set wins over a clear in the same cycle
        if (event_i) begin
            st_next.flag = 1'b1;
        end else if (clear_i) begin
            st_next.flag = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '{flag: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag_o = st_reg.flag;

    AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        event_i |=> flag_o)
        else $error("fault event lost");
    AST_CLEAR_ONLY: assert property (@(posedge clk_i) disable iff (!rstn_i)
        flag_o && !clear_i |=> flag_o)
        else $error("flag dropped without clear");
endmodule

/* core/fie_top.sv */
// Module: fault detection configuration, interrupt enables and fault interrupt of the backlight driver
`timescale 1ns/1ns
module fie_top
    import fie_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    // Fault sources from the detectors: 13..7 supply, 6..0 boost
    input wire logic [13:0] FAULT_I,
    // Detector configuration
    output logic GND_SHORT_DETECT_ON_O,
    output logic [5:0] INTERNAL_SHORT_OFF_O,
    // Interrupt
    output logic IRQ_O
);
    import fie_pkg::*;

    // ==========================================
    // State
    typedef struct packed {
        logic [13:0] fault_meta;
        logic [13:0] fault_sync;
        logic [15:0] detect_cfg;
        logic [13:0] mask;
        logic [15:0] rdata;
        logic irq;
    } fie_state_s;

    fie_state_s st_reg;
    fie_state_s st_next;
    fie_bus_s bus;
    fie_detect_s det;

    logic [15:0] supply_rd;
    logic [15:0] boost_rd;
    logic [13:0] src_on;
    logic [13:0] status;
    logic [13:0] clr;
    logic [15:0] stat_rd;
    logic wr_supply;
    logic wr_boost;
    logic wr_clear;

    assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
    assign wr_supply = bus.wr && bus.addr == FIE_OFF_SUPPLY_EN;
    assign wr_boost = bus.wr && bus.addr == FIE_OFF_BOOST_EN;
    assign wr_clear = bus.wr && bus.addr == FIE_OFF_STAT_CLEAR;

    // ==========================================
    // Enable fields
    genvar gi;
    generate
        for (gi = 0; gi < FIE_SUPPLY_FIELDS; gi++) begin : g_supply
            fie_en_field #(.RESET_ON(FIE_RST_SUPPLY_EN[2*gi+1])) u_field (
                .clk_i(REF_CLK_I),
                .rstn_i(RSTN_I),
                .wr_i(wr_supply),
                .code_i(bus.wdata[2*gi +: 2]),
                .on_o(src_on[FIE_BOOST_FIELDS + gi]),
                .rd_code_o(supply_rd[2*gi +: 2])
            );
        end
        for (gi = 0; gi < FIE_BOOST_FIELDS; gi++) begin : g_boost
            // Strap-resistor enables come out of reset off per the reset word
            fie_en_field #(.RESET_ON(FIE_RST_BOOST_EN[2*(gi+FIE_BOOST_FIRST)+1])) u_field (
                .clk_i(REF_CLK_I),
                .rstn_i(RSTN_I),
                .wr_i(wr_boost),
                .code_i(bus.wdata[2*(gi+FIE_BOOST_FIRST) +: 2]),
                .on_o(src_on[gi]),
                .rd_code_o(boost_rd[2*(gi+FIE_BOOST_FIRST) +: 2])
            );
        end
        // Sticky status: a bit clears only when written together with the shared clear bit
        for (gi = 0; gi < FIE_SOURCES; gi++) begin : g_stat
            assign clr[gi] = wr_clear && bus.wdata[gi] && bus.wdata[FIE_SOURCES] ;
            fie_sticky u_flag (
                .clk_i(REF_CLK_I),
                .rstn_i(RSTN_I),
                .event_i(st_reg.fault_sync[gi] && src_on[gi]),
                .clear_i(clr[gi]),
                .flag_o(status[gi])
            );
        end
    endgenerate

    assign supply_rd[15:2*FIE_SUPPLY_FIELDS] = '0;
    assign boost_rd[2*FIE_BOOST_FIRST-1:0] = '0;
    assign stat_rd = {2'h0, status};

    // ==========================================
    // Register file and interrupt
    always_comb begin
        st_next = st_reg;
        st_next.fault_meta = FAULT_I;
        st_next.fault_sync = st_reg.fault_meta;
        if (bus.wr && bus.addr == FIE_OFF_DETECT_CFG) begin
            // Bits 7..6 are not stored, so a nonzero write there cannot upset detection
            st_next.detect_cfg = bus.wdata & FIE_DETECT_CFG_MASK;
        end
        if (bus.wr && bus.addr == FIE_OFF_FAULT_MASK) begin
            st_next.mask = bus.wdata[13:0];
        end
        st_next.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                FIE_OFF_DETECT_CFG: st_next.rdata = st_reg.detect_cfg;
                FIE_OFF_SUPPLY_EN: st_next.rdata = supply_rd;
                FIE_OFF_BOOST_EN: st_next.rdata = boost_rd;
                FIE_OFF_FAULT_STAT: st_next.rdata = stat_rd;
                FIE_OFF_FAULT_MASK: st_next.rdata = {2'h0, st_reg.mask};
                default: st_next.rdata = '0;
            endcase
        end
        st_next.irq = |(status & st_reg.mask);
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_reg <= '{fault_meta: '0, fault_sync: '0, detect_cfg: FIE_RST_DETECT_CFG,
                        mask: FIE_RST_MASK[13:0], rdata: '0, irq: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign det = '{ground_short_detect_on: st_reg.detect_cfg[FIE_GND_DET_BIT],
                   internal_short_off: st_reg.detect_cfg[FIE_STRINGS-1:0]};
    assign GND_SHORT_DETECT_ON_O = det.ground_short_detect_on;
    assign INTERNAL_SHORT_OFF_O = det.internal_short_off;
    assign RDATA_O = st_reg.rdata;
    assign IRQ_O = st_reg.irq;

    // ==========================================
    // Checks
    AST_IRQ_FOLLOWS: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        ##1 IRQ_O == |($past(status) & $past(st_reg.mask)))
        else $error("interrupt does not follow masked status");
    AST_NO_DISABLED_SRC: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        ##1 (status & ~$past(status) & ~($past(st_reg.fault_sync) & $past(src_on))) == '0)
        else $error("status set without an enabled fault");
    AST_CFG_WRITE: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        bus.wr && bus.addr == FIE_OFF_DETECT_CFG |=> GND_SHORT_DETECT_ON_O == $past(WDATA_I[8]))
        else $error("ground detect bit not written");
    AST_STR_WRITE: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        bus.wr && bus.addr == FIE_OFF_DETECT_CFG |=> INTERNAL_SHORT_OFF_O == $past(WDATA_I[5:0]))
        else $error("string short bits not written");
    AST_RD_CODE: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        bus.rd && bus.addr == FIE_OFF_SUPPLY_EN |=> RDATA_O[1:0] == {$past(src_on[7]), 1'b0})
        else $error("enable read code wrong");
    AST_BOOST_RSVD: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        bus.rd && bus.addr == FIE_OFF_BOOST_EN |=> RDATA_O[1:0] == 2'h0)
        else $error("reserved boost bits nonzero");
    AST_SUPPLY_RSVD: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        bus.rd && bus.addr == FIE_OFF_SUPPLY_EN |=> RDATA_O[15:14] == 2'h0)
        else $error("reserved supply bits nonzero");
    AST_CFG_RSVD: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        bus.rd && bus.addr == FIE_OFF_DETECT_CFG |=> RDATA_O[7:6] == 2'h0)
        else $error("config bits 7..6 nonzero");
endmodule

/* verif/fie_top_tb.sv */
// Testbench: register map, enable fields and fault interrupt of the fault interrupt-enable block
`timescale 1ns/1ns
module fie_top_tb;
    import fie_pkg::*;
    // ==========================================
    // Stimulus, observation and bookkeeping
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [13:0] fault = 14'h0000;
    logic [15:0] rdata;
    logic gnd_on;
    logic [5:0] short_off;
    logic irq;
    int fails = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'd77;
    // Bench view of the enables: supply all on, boost strap-resistor fields off
    logic [6:0] sup_en = 7'h7F;
    logic [6:0] bst_en = 7'h63;

    always #10 clk = ~clk;

    fie_top u_fie_top (.REF_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .FAULT_I(fault), .GND_SHORT_DETECT_ON_O(gnd_on),
        .INTERNAL_SHORT_OFF_O(short_off), .IRQ_O(irq));

    // ==========================================
    // Reference functions
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    // Codes other than off and on leave the field alone
    function automatic logic [6:0] upd(logic [6:0] en, logic [15:0] d, int base);
        logic [6:0] r;
        r = en;
        for (int i = 0; i < 7; i++) begin
            if (d[2*i+base +: 2] == 2'h1) r[i] = 1'b0;
            if (d[2*i+base +: 2] == 2'h3) r[i] = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [15:0] img(logic [6:0] en, int base);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 7; i++) begin
            r[2*i+base +: 2] = en[i] ? 2'h2 : 2'h0;
        end
        return r;
    endfunction

    // ==========================================
    // Bus tasks and comparison
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe is taken
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        logic [15:0] d;
        logic [15:0] st;
        logic [13:0] m;
        logic hit;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(FIE_OFF_DETECT_CFG, 16'h0100, "cfg reset");
        rd_chk(FIE_OFF_SUPPLY_EN, 16'h2AAA, "supply reset");
        rd_chk(FIE_OFF_BOOST_EN, 16'hA028, "boost reset");
        rd_chk(FIE_OFF_FAULT_MASK, {2'b00, FIE_RST_MASK[13:0]}, "mask reset");
        rd_chk(FIE_OFF_FAULT_STAT, 16'h0000, "status reset");
        rd_chk(8'h20, 16'h0000, "unmapped");
        chk("gnd out", 16'h0001, {15'h0, gnd_on});
        chk("short out", 16'h0000, {10'h0, short_off});
        chk("irq", 16'h0000, {15'h0, irq});
        $display("test reset done");
        for (int k = 0; k < 10; k++) begin
            d = (k == 0) ? 16'h0000 : (k == 1) ? 16'hFF3F : (rnd() & 16'hFF3F);
            wr_reg(FIE_OFF_DETECT_CFG, d);
            rd_chk(FIE_OFF_DETECT_CFG, d & 16'h013F, "cfg read");
            chk("gnd out", {15'h0, d[8]}, {15'h0, gnd_on});
            chk("short out", {10'h0, d[5:0]}, {10'h0, short_off});
        end
        $display("test config done");
        for (int k = 0; k < 40; k++) begin
            // First four words put codes 1h, 2h, 3h and 0h into every field
            d = (k < 4) ? {8{k[1:0] + 2'h1}} : rnd();
            wr_reg(FIE_OFF_SUPPLY_EN, d);
            sup_en = upd(sup_en, d, 0);
            wr_reg(FIE_OFF_BOOST_EN, d);
            bst_en = upd(bst_en, d, 2);
            rd_chk(FIE_OFF_SUPPLY_EN, img(sup_en, 0), "supply read");
            rd_chk(FIE_OFF_BOOST_EN, img(bst_en, 2), "boost read");
        end
        $display("test enables done");
        d = rnd();
        m = d[13:0];
        wr_reg(FIE_OFF_FAULT_MASK, {2'b00, m});
        rd_chk(FIE_OFF_FAULT_MASK, {2'b00, m}, "mask read");
        for (int s = 0; s < 14; s++) begin
            hit = (s > 6) ? sup_en[s-7] : bst_en[s];
            st = hit ? (16'h0001 << s) : 16'h0000;
            @(posedge clk);
            fault <= 14'h0001 << s;
            repeat (6) @(posedge clk);
            #1;
            chk("irq raised", {15'h0, hit & m[s]}, {15'h0, irq});
            @(posedge clk);
            fault <= 14'h0000;
            rd_chk(FIE_OFF_FAULT_STAT, st, "status set");
            // Status bit alone, without the clear bit, must not clear
            wr_reg(FIE_OFF_STAT_CLEAR, 16'h0001 << s);
            rd_chk(FIE_OFF_FAULT_STAT, st, "status kept");
            wr_reg(FIE_OFF_STAT_CLEAR, 16'h4000 | (16'h0001 << s));
            rd_chk(FIE_OFF_FAULT_STAT, 16'h0000, "status cleared");
            chk("irq cleared", 16'h0000, {15'h0, irq});
        end
        $display("test interrupts done");
        stop_test();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        $display("BAD watchdog expected finish seen timeout");
        stop_test();
    end
endmodule
